//--- pbs_pkg.sv
// constants and types for the regulator status and disable-timing register slice
// What this block does
// - per-output fall time, reset 500 us
// - fall time used only after commit
// - per-output disable delay, 10 us steps
// - global read-only one-byte fault summary
// - summary bit 6: output not delivering
// - bits 5/4/3: vout ov, iout oc, vin uv
// - bits 2/1/0: temp, comm, other; 7 unused
// - word low byte equals summary byte
// - word bits 15..12: vout, iout, input, vendor
// - word bit 11: power not good
// - vout byte: ov 7, uv 4, max 3
// - iout byte: oc 7, oc-uv 6, share 3
// - input byte: ov 7, uv 3, oc 2
// - input uv masked until vin first rises
// - temp byte: ot 7, warn 6, ut 4
// - vout/iout bytes selected by page
// - status bytes read-only, fed by detection
// - global comm/logic/memory detail byte
// - comm byte: cmd 7, data 6, pec 5
// - overheat warning sets temp bits
`default_nettype none
package pbs_pkg;

    // ************************************************************
    // command codes
    // ************************************************************
    localparam logic [7:0] CMD_DISABLE_DELAY = 8'h64;
    localparam logic [7:0] CMD_DISABLE_FALL  = 8'h65;
    localparam logic [7:0] CMD_SUM_BYTE      = 8'h78;
    localparam logic [7:0] CMD_SUM_WORD      = 8'h79;
    localparam logic [7:0] CMD_VOUT_FAULTS   = 8'h7A;
    localparam logic [7:0] CMD_IOUT_FAULTS   = 8'h7B;
    localparam logic [7:0] CMD_INPUT_FAULTS  = 8'h7C;
    localparam logic [7:0] CMD_THERM_FAULTS  = 8'h7D;
    localparam logic [7:0] CMD_CML_FAULTS    = 8'h7E;

    // ************************************************************
    // reset values, units and limits
    // ************************************************************
    localparam logic [15:0] DELAY_RESET   = 16'h0000;
    localparam logic [15:0] FALL_RESET    = 16'h01F4;
    localparam int          DELAY_STEP_US = 10;
    localparam logic [15:0] FALL_MAX_US   = 16'h2710;

    // ************************************************************
    // bit positions
    // ************************************************************
    localparam int SB_OFF = 6;
    localparam int SB_VOV = 5;
    localparam int SB_IOC = 4;
    localparam int SB_VUV = 3;
    localparam int SB_TMP = 2;
    localparam int SB_CML = 1;
    localparam int SB_OTH = 0;
    localparam int SW_VOUT = 15;
    localparam int SW_IOUT = 14;
    localparam int SW_INP  = 13;
    localparam int SW_MFR  = 12;
    localparam int SW_PGN  = 11;
    localparam int VO_OV  = 7;
    localparam int VO_UV  = 4;
    localparam int VO_MAX = 3;
    localparam int IO_OC   = 7;
    localparam int IO_OCUV = 6;
    localparam int IO_SHR  = 3;
    localparam int IN_OV = 7;
    localparam int IN_UV = 3;
    localparam int IN_OC = 2;
    localparam int TP_OT   = 7;
    localparam int TP_WARN = 6;
    localparam int TP_UT   = 4;
    localparam int CM_CMD  = 7;
    localparam int CM_DATA = 6;
    localparam int CM_PEC  = 5;
    localparam int CM_MEM  = 4;
    localparam int CM_PROC = 3;
    localparam int CM_COMM = 1;
    localparam int CM_OTH  = 0;

    // ************************************************************
    // state types
    // ************************************************************
    typedef struct packed {
        logic [15:0] delay;
        logic [15:0] fall_pend;
        logic [15:0] fall_act;
    } pbs_set_t;

    typedef struct packed {
        logic [1:0]  vout_ov;
        logic [1:0]  vout_uv;
        logic [1:0]  vout_max;
        logic [1:0]  iout_oc;
        logic [1:0]  iout_ocuv;
        logic [1:0]  iout_share;
        logic        in_ov;
        logic        in_uv;
        logic        in_oc;
        logic        uv_armed;
        logic [7:0]  temp;
        logic [7:0]  comm_memory_logic_flag;
        logic        vendor;
        logic        other;
        logic [15:0] rdata;
        logic        rvalid;
        logic        err;
    } pbs_stat_t;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic pbs_code_known(input logic [7:0] code);
        return (code == CMD_DISABLE_DELAY) || (code == CMD_DISABLE_FALL) ||
               ((code >= CMD_SUM_BYTE) && (code <= CMD_CML_FAULTS));
    endfunction

    function automatic logic pbs_code_writable(input logic [7:0] code);
        return (code == CMD_DISABLE_DELAY) || (code == CMD_DISABLE_FALL);
    endfunction

endpackage
`default_nettype wire

//--- pbs_page_settings.sv
// per-output disable delay and staged fall-time settings
`timescale 1ns/1ns
`default_nettype none
module pbs_page_settings
    import pbs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wr_delay,
    input  wire logic        wr_fall,
    input  wire logic [15:0] wdata,
    input  wire logic        commit,
    output logic      [15:0] delay_val,
    output logic      [15:0] fall_pend,
    output logic      [15:0] fall_act
);

    pbs_set_t s_r;
    pbs_set_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (wr_delay) begin
            s_nxt.delay = wdata;
        end
        if (wr_fall) begin
            s_nxt.fall_pend = wdata;
        end
        if (commit) begin
            s_nxt.fall_act = wr_fall ? wdata : s_r.fall_pend;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r.delay     <= DELAY_RESET;
            s_r.fall_pend <= FALL_RESET;
            s_r.fall_act  <= FALL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign delay_val = s_r.delay;
    assign fall_pend = s_r.fall_pend;
    assign fall_act  = s_r.fall_act;

endmodule // pbs_page_settings
`default_nettype wire

//--- pbs_status_bank.sv
// status reporting and disable-timing command registers of a dual-output regulator
`timescale 1ns/1ns
`default_nettype none
module pbs_status_bank
    import pbs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    // command port from the serial interface
    input  wire logic        cmd_stb,
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        cmd_page,
    input  wire logic        commit_stb,
    input  wire logic        clear_stb,
    input  wire logic        pec_err_stb,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic             cmd_err,
    // per-output detection events
    input  wire logic [1:0]  out_on,
    input  wire logic [1:0]  out_power_good,
    input  wire logic [1:0]  vout_ov_evt,
    input  wire logic [1:0]  vout_uv_evt,
    input  wire logic [1:0]  vout_max_evt,
    input  wire logic [1:0]  iout_oc_evt,
    input  wire logic [1:0]  iout_ocuv_evt,
    input  wire logic [1:0]  iout_share_evt,
    // global detection events
    input  wire logic        vin_ov_evt,
    input  wire logic        vin_uv_evt,
    input  wire logic        vin_above_uv,
    input  wire logic        iin_oc_evt,
    input  wire logic        ot_fault_evt,
    input  wire logic        ot_warn_evt,
    input  wire logic        ut_fault_evt,
    input  wire logic        mem_fault_evt,
    input  wire logic        proc_fault_evt,
    input  wire logic        comm_other_evt,
    input  wire logic        logic_other_evt,
    input  wire logic        vendor_evt,
    input  wire logic        other_change_evt,
    // applied disable timing per output
    output logic      [15:0] delay_val_0,
    output logic      [15:0] delay_val_1,
    output logic      [15:0] fall_act_0,
    output logic      [15:0] fall_act_1
);

    // ************************************************************
    // per-output settings
    // ************************************************************
    logic        acc_rd;
    logic        acc_wr;
    logic        known;
    logic        bad_data;
    logic [1:0]  wr_delay;
    logic [1:0]  wr_fall;
    logic [15:0] delay_v [2];
    logic [15:0] fall_p  [2];
    logic [15:0] fall_a  [2];

    assign acc_rd   = cmd_stb && !cmd_wr;
    assign acc_wr   = cmd_stb && cmd_wr;
    assign known    = pbs_code_known(cmd_code);
    assign bad_data = acc_wr && known &&
                      (!pbs_code_writable(cmd_code) ||
                       ((cmd_code == CMD_DISABLE_FALL) && (cmd_wdata > FALL_MAX_US)));

    always_comb begin
        wr_delay = 2'b00;
        wr_fall  = 2'b00;
        if (acc_wr && !bad_data && (cmd_code == CMD_DISABLE_DELAY)) begin
            wr_delay[cmd_page] = 1'b1;
        end
        if (acc_wr && !bad_data && (cmd_code == CMD_DISABLE_FALL)) begin
            wr_fall[cmd_page] = 1'b1;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_page
        pbs_page_settings u_set (
            .clk       (clk),
            .rst       (rst),
            .wr_delay  (wr_delay[g]),
            .wr_fall   (wr_fall[g]),
            .wdata     (cmd_wdata),
            .commit    (commit_stb),
            .delay_val (delay_v[g]),
            .fall_pend (fall_p[g]),
            .fall_act  (fall_a[g])
        );
    end

    assign delay_val_0 = delay_v[0];
    assign delay_val_1 = delay_v[1];
    // host must commit in or after the cycle of the fall-time write
    assign fall_act_0  = fall_a[0];
    assign fall_act_1  = fall_a[1];

    // ************************************************************
    // status state
    // ************************************************************
    pbs_stat_t st_r;
    pbs_stat_t st_nxt;

    logic [7:0]  vout_byte [2];
    logic [7:0]  iout_byte [2];
    logic [7:0]  input_byte;
    logic [7:0]  sum_byte;
    logic [15:0] sum_word;
    logic        any_vout;
    logic        any_iout;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            vout_byte[i]         = 8'h00;
            vout_byte[i][VO_OV]  = st_r.vout_ov[i];
            vout_byte[i][VO_UV]  = st_r.vout_uv[i];
            vout_byte[i][VO_MAX] = st_r.vout_max[i];
            iout_byte[i]          = 8'h00;
            iout_byte[i][IO_OC]   = st_r.iout_oc[i];
            iout_byte[i][IO_OCUV] = st_r.iout_ocuv[i];
            iout_byte[i][IO_SHR]  = st_r.iout_share[i];
        end
    end

    always_comb begin
        input_byte        = 8'h00;
        input_byte[IN_OV] = st_r.in_ov;
        input_byte[IN_UV] = st_r.in_uv;
        input_byte[IN_OC] = st_r.in_oc;
    end

    assign any_vout = |{vout_byte[0], vout_byte[1]};
    assign any_iout = |{iout_byte[0], iout_byte[1]};

    always_comb begin
        sum_byte = 8'h00;
        sum_byte[SB_OFF] = !(&out_on);
        sum_byte[SB_VOV] = |st_r.vout_ov;
        sum_byte[SB_IOC] = |st_r.iout_oc;
        sum_byte[SB_VUV] = st_r.in_uv;
        sum_byte[SB_TMP] = |st_r.temp;
        sum_byte[SB_CML] = |st_r.comm_memory_logic_flag;
        sum_byte[SB_OTH] = st_r.other;
    end

    always_comb begin
        sum_word = {8'h00, sum_byte};
        sum_word[SW_VOUT] = any_vout;
        sum_word[SW_IOUT] = any_iout;
        sum_word[SW_INP]  = |input_byte;
        sum_word[SW_MFR]  = st_r.vendor;
        sum_word[SW_PGN]  = !(&out_power_good);
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        if (clear_stb) begin
            st_nxt.vout_ov    = 2'b00;
            st_nxt.vout_uv    = 2'b00;
            st_nxt.vout_max   = 2'b00;
            st_nxt.iout_oc    = 2'b00;
            st_nxt.iout_ocuv  = 2'b00;
            st_nxt.iout_share = 2'b00;
            st_nxt.in_ov      = 1'b0;
            st_nxt.in_uv      = 1'b0;
            st_nxt.in_oc      = 1'b0;
            st_nxt.temp       = 8'h00;
            st_nxt.comm_memory_logic_flag        = 8'h00;
            st_nxt.vendor     = 1'b0;
            st_nxt.other      = 1'b0;
        end
        st_nxt.vout_ov    = st_nxt.vout_ov | vout_ov_evt;
        st_nxt.vout_uv    = st_nxt.vout_uv | vout_uv_evt;
        st_nxt.vout_max   = st_nxt.vout_max | vout_max_evt;
        st_nxt.iout_oc    = st_nxt.iout_oc | iout_oc_evt;
        st_nxt.iout_ocuv  = st_nxt.iout_ocuv | iout_ocuv_evt;
        st_nxt.iout_share = st_nxt.iout_share | iout_share_evt;
        st_nxt.in_ov      = st_nxt.in_ov | vin_ov_evt;
        st_nxt.in_oc      = st_nxt.in_oc | iin_oc_evt;
        if (vin_above_uv) begin
            st_nxt.uv_armed = 1'b1;
        end
        st_nxt.in_uv = st_nxt.in_uv | (vin_uv_evt && st_r.uv_armed);
        st_nxt.temp[TP_OT] = st_nxt.temp[TP_OT] | ot_fault_evt;
        st_nxt.temp[TP_WARN] = st_nxt.temp[TP_WARN] | ot_warn_evt;
        st_nxt.temp[TP_UT]   = st_nxt.temp[TP_UT] | ut_fault_evt;
        st_nxt.comm_memory_logic_flag[CM_CMD]  = st_nxt.comm_memory_logic_flag[CM_CMD] | (cmd_stb && !known);
        st_nxt.comm_memory_logic_flag[CM_DATA] = st_nxt.comm_memory_logic_flag[CM_DATA] | bad_data;
        st_nxt.comm_memory_logic_flag[CM_PEC]  = st_nxt.comm_memory_logic_flag[CM_PEC] | pec_err_stb;
        st_nxt.comm_memory_logic_flag[CM_MEM]  = st_nxt.comm_memory_logic_flag[CM_MEM] | mem_fault_evt;
        st_nxt.comm_memory_logic_flag[CM_PROC] = st_nxt.comm_memory_logic_flag[CM_PROC] | proc_fault_evt;
        st_nxt.comm_memory_logic_flag[CM_COMM] = st_nxt.comm_memory_logic_flag[CM_COMM] | comm_other_evt;
        st_nxt.comm_memory_logic_flag[CM_OTH]  = st_nxt.comm_memory_logic_flag[CM_OTH] | logic_other_evt;
        st_nxt.vendor = st_nxt.vendor | vendor_evt;
        st_nxt.other  = st_nxt.other | other_change_evt;

        // read answer one cycle after the strobe
        st_nxt.rvalid = acc_rd && known;
        st_nxt.err    = cmd_stb && (!known || bad_data);
        if (acc_rd) begin
            case (cmd_code)
                CMD_DISABLE_DELAY: st_nxt.rdata = delay_v[cmd_page];
                CMD_DISABLE_FALL:  st_nxt.rdata = fall_p[cmd_page];
                CMD_SUM_BYTE:      st_nxt.rdata = {8'h00, sum_byte};
                CMD_SUM_WORD:      st_nxt.rdata = sum_word;
                CMD_VOUT_FAULTS:   st_nxt.rdata = {8'h00, vout_byte[cmd_page]};
                CMD_IOUT_FAULTS:   st_nxt.rdata = {8'h00, iout_byte[cmd_page]};
                CMD_INPUT_FAULTS:  st_nxt.rdata = {8'h00, input_byte};
                CMD_THERM_FAULTS:  st_nxt.rdata = {8'h00, st_r.temp};
                CMD_CML_FAULTS:    st_nxt.rdata = {8'h00, st_r.comm_memory_logic_flag};
                default:           st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rd_data  = st_r.rdata;
    assign rd_valid = st_r.rvalid;
    assign cmd_err  = st_r.err;

endmodule // pbs_status_bank
`default_nettype wire

//--- pbs_status_bank_assertions.sv
// concurrent checks on the command port and settings of the status bank
`timescale 1ns/1ns
`default_nettype none
module pbs_status_bank_checker (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cmd_stb,
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        commit_stb,
    input  wire logic        vin_above_uv,
    input  wire logic [1:0]  out_on,
    input  wire logic [1:0]  out_power_good,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    input  wire logic        cmd_err,
    input  wire logic [15:0] fall_act_0,
    input  wire logic [15:0] fall_act_1
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic ro;
    logic known;
    logic rd;
    logic seen_r;
    assign ro    = (cmd_code >= 8'h78) && (cmd_code <= 8'h7E);
    assign known = ro || (cmd_code == 8'h64) || (cmd_code == 8'h65);
    assign rd    = cmd_stb && !cmd_wr;
    // remembers that the input rose above the undervoltage level once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_r <= 1'b0;
        end
        else if (vin_above_uv) begin
            seen_r <= 1'b1;
        end
    end
    AST_READ_ANSWER:
        assert property (rd && known |=> rd_valid && !cmd_err)
        else $error("read of a known code gave no answer");
    AST_IDLE_QUIET:
        assert property (!cmd_stb |=> !rd_valid && !cmd_err)
        else $error("answer without a command");
    AST_WRITE_RO:
        assert property (cmd_stb && cmd_wr && ro |=> cmd_err && !rd_valid)
        else $error("write to a status code not refused");
    AST_UNKNOWN:
        assert property (cmd_stb && !known |=> cmd_err && !rd_valid)
        else $error("unknown code not refused");
    AST_SUM_BYTE:
        assert property (rd && cmd_code == 8'h78 |=> rd_data[15:7] == 9'h000
                         && rd_data[6] == ($past(out_on) != 2'b11))
        else $error("summary byte off or unused bits wrong");
    AST_WORD_PGOOD:
        assert property (rd && cmd_code == 8'h79 |=> rd_data[10:7] == 4'h0
                         && rd_data[11] == ($past(out_power_good) != 2'b11)
                         && rd_data[6] == ($past(out_on) != 2'b11))
        else $error("status word power bits wrong");
    AST_DETAIL_UNUSED:
        assert property (rd && (cmd_code == 8'h7A || cmd_code == 8'h7B) |=>
                         rd_data[15:8] == 8'h00 && !rd_data[5] && rd_data[2:0] == 3'h0)
        else $error("output detail byte has unused bits set");
    AST_INPUT_MASK:
        assert property (rd && cmd_code == 8'h7C && !seen_r |=> !rd_data[3])
        else $error("input undervoltage reported before arming");
    AST_FALL_HOLD:
        assert property (!commit_stb |=> $stable(fall_act_0) && $stable(fall_act_1))
        else $error("applied fall time moved without commit");
    COV_WORD_OFF: cover property (rd && cmd_code == 8'h79 && out_on != 2'b11);
    COV_COMMIT: cover property (commit_stb);
    COV_REFUSE: cover property (cmd_stb ##1 cmd_err);
endmodule // pbs_status_bank_checker

bind pbs_status_bank pbs_status_bank_checker pbs_status_bank_checker_inst (
    .clk(clk), .rst(rst), .cmd_stb(cmd_stb), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .commit_stb(commit_stb), .vin_above_uv(vin_above_uv), .out_on(out_on),
    .out_power_good(out_power_good), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_err(cmd_err), .fall_act_0(fall_act_0), .fall_act_1(fall_act_1)
);
`default_nettype wire

//--- pbs_host.sv
// host model issuing commands and control pulses to the status bank
`timescale 1ns/1ns
`default_nettype none
module pbs_host (
    input  wire logic        clk,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    input  wire logic        cmd_err,
    output logic             cmd_stb,
    output logic             cmd_wr,
    output logic      [7:0]  cmd_code,
    output logic      [15:0] cmd_wdata,
    output logic             cmd_page,
    output logic             commit_stb,
    output logic             clear_stb,
    output logic             pec_err_stb
);
    initial begin
        {cmd_stb, cmd_wr, cmd_page, commit_stb, clear_stb, pec_err_stb} = 6'h00;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // one command; answer taken at the edge after the strobe
    task automatic xfer(input logic wr, input logic [7:0] code, input logic pg,
                        input logic [15:0] wd, output logic [15:0] rdv,
                        output logic ok, output logic err);
        @(posedge clk);
        #1;
        {cmd_stb, cmd_wr, cmd_code, cmd_page, cmd_wdata} = {1'b1, wr, code, pg, wd};
        @(posedge clk);
        #1;
        rdv = rd_data;
        ok  = rd_valid;
        err = cmd_err;
        cmd_stb   = 1'b0;
        cmd_code  = ~code;
        cmd_wdata = ~wd;
    endtask
    task automatic pulse(input logic [2:0] sel);
        @(posedge clk);
        #1;
        {commit_stb, clear_stb, pec_err_stb} = sel;
        @(posedge clk);
        #1;
        {commit_stb, clear_stb, pec_err_stb} = 3'h0;
    endtask
endmodule // pbs_host
`default_nettype wire

//--- pbs_status_bank_test.sv
// self-checking bench for the status and disable-timing register slice
`timescale 1ns/1ns
`default_nettype none
module pbs_status_bank_test;
    logic        clk, rst, stb, wr, pg, commit, clr_s, pec, rvld, err;
    logic [7:0]  code;
    logic [15:0] wd, rdat, dly0, dly1, fa0, fa1;
    logic [1:0]  on, pgood, vov, vuv, vmax, ioc, iocuv, ishr;
    logic        vin_ov, vin_uv, vin_ok, iin_oc, ot_f, ot_w, ut_f;
    logic        mem_f, proc_f, comm_o, logic_o, vend, oth;
    int          errors, tests_run, cycles;

    pbs_status_bank pbs_status_bank_inst (
        .clk(clk), .rst(rst), .cmd_stb(stb), .cmd_wr(wr), .cmd_code(code),
        .cmd_wdata(wd), .cmd_page(pg), .commit_stb(commit), .clear_stb(clr_s),
        .pec_err_stb(pec), .rd_data(rdat), .rd_valid(rvld), .cmd_err(err),
        .out_on(on), .out_power_good(pgood), .vout_ov_evt(vov), .vout_uv_evt(vuv),
        .vout_max_evt(vmax), .iout_oc_evt(ioc), .iout_ocuv_evt(iocuv),
        .iout_share_evt(ishr), .vin_ov_evt(vin_ov), .vin_uv_evt(vin_uv),
        .vin_above_uv(vin_ok), .iin_oc_evt(iin_oc), .ot_fault_evt(ot_f),
        .ot_warn_evt(ot_w), .ut_fault_evt(ut_f), .mem_fault_evt(mem_f),
        .proc_fault_evt(proc_f), .comm_other_evt(comm_o), .logic_other_evt(logic_o),
        .vendor_evt(vend), .other_change_evt(oth), .delay_val_0(dly0),
        .delay_val_1(dly1), .fall_act_0(fa0), .fall_act_1(fa1)
    );
    pbs_host pbs_host_inst (
        .clk(clk), .rd_data(rdat), .rd_valid(rvld), .cmd_err(err), .cmd_stb(stb),
        .cmd_wr(wr), .cmd_code(code), .cmd_wdata(wd), .cmd_page(pg),
        .commit_stb(commit), .clear_stb(clr_s), .pec_err_stb(pec)
    );

    always #5 clk = ~clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end
        else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic rdc(input string name, input logic [7:0] c, input logic p,
                       input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        logic e;
        pbs_host_inst.xfer(1'b0, c, p, 16'h0000, d, v, e);
        chk({name, " valid"}, {15'h0000, v}, 16'h0001);
        chk(name, d, exp);
    endtask
    task automatic wrc(input logic w, input logic [7:0] c, input logic p,
                       input logic [15:0] dat, input logic exp_err);
        logic [15:0] d;
        logic v;
        logic e;
        pbs_host_inst.xfer(w, c, p, dat, d, v, e);
        chk("refusal", {15'h0000, e}, {15'h0000, exp_err});
    endtask
    task automatic clr();
        pbs_host_inst.pulse(3'b010);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        rdc("delay p0", 8'h64, 1'b0, 16'h0000);
        rdc("fall p1", 8'h65, 1'b1, 16'h01F4);
        chk("fall_act_0", fa0, 16'h01F4);
        chk("delay_val_1", dly1, 16'h0000);
    endtask
    task automatic t_fall();
        wrc(1'b1, 8'h65, 1'b1, 16'h2710, 1'b0);
        rdc("fall staged", 8'h65, 1'b1, 16'h2710);
        chk("fall_act_1 held", fa1, 16'h01F4);
        pbs_host_inst.pulse(3'b100);
        tick();
        chk("fall_act_1", fa1, 16'h2710);
        chk("fall_act_0", fa0, 16'h01F4);
        wrc(1'b1, 8'h65, 1'b0, 16'h2711, 1'b1);
        rdc("fall kept", 8'h65, 1'b0, 16'h01F4);
        wrc(1'b1, 8'h64, 1'b0, 16'hFFFF, 1'b0);
        tick();
        chk("delay_val_0", dly0, 16'hFFFF);
        chk("delay_val_1", dly1, 16'h0000);
    endtask
    task automatic t_vout();
        clr();
        {vov, vmax, vuv} = 6'b10_01_01;
        tick();
        {vov, vmax, vuv} = 6'h00;
        rdc("vout p1", 8'h7A, 1'b1, 16'h0080);
        rdc("vout p0", 8'h7A, 1'b0, 16'h0018);
        rdc("byte vout", 8'h78, 1'b0, 16'h0020);
        rdc("word vout", 8'h79, 1'b0, 16'h8020);
        clr();
        rdc("vout cleared", 8'h7A, 1'b1, 16'h0000);
    endtask
    task automatic t_iout();
        {ioc, ishr, iocuv} = 6'b01_10_10;
        tick();
        {ioc, ishr, iocuv} = 6'h00;
        rdc("iout p0", 8'h7B, 1'b0, 16'h0080);
        rdc("iout p1", 8'h7B, 1'b1, 16'h0048);
        rdc("word iout", 8'h79, 1'b0, 16'h4010);
    endtask
    task automatic t_input();
        clr();
        vin_uv = 1'b1;
        tick();
        vin_uv = 1'b0;
        rdc("input masked", 8'h7C, 1'b0, 16'h0000);
        vin_ok = 1'b1;
        tick();
        {vin_uv, vin_ov, iin_oc} = 3'b111;
        tick();
        {vin_uv, vin_ov, iin_oc} = 3'b000;
        rdc("input", 8'h7C, 1'b0, 16'h008C);
        rdc("word input", 8'h79, 1'b0, 16'h2008);
    endtask
    task automatic t_temp();
        clr();
        ot_w = 1'b1;
        tick();
        ot_w = 1'b0;
        rdc("temp warn", 8'h7D, 1'b0, 16'h0040);
        rdc("byte temp", 8'h78, 1'b0, 16'h0004);
        {ot_f, ut_f} = 2'b11;
        tick();
        {ot_f, ut_f} = 2'b00;
        rdc("temp all", 8'h7D, 1'b0, 16'h00D0);
    endtask
    task automatic t_cml();
        clr();
        wrc(1'b1, 8'h78, 1'b0, 16'h00FF, 1'b1);
        wrc(1'b0, 8'h70, 1'b0, 16'h0000, 1'b1);
        pbs_host_inst.pulse(3'b001);
        {mem_f, proc_f, comm_o, logic_o} = 4'hF;
        tick();
        {mem_f, proc_f, comm_o, logic_o} = 4'h0;
        rdc("cml", 8'h7E, 1'b0, 16'h00FB);
        rdc("word cml", 8'h79, 1'b0, 16'h0002);
    endtask
    task automatic t_off();
        clr();
        {on, pgood, vend, oth} = 6'b10_01_11;
        tick();
        {vend, oth} = 2'b00;
        rdc("byte off", 8'h78, 1'b0, 16'h0041);
        rdc("word off", 8'h79, 1'b0, 16'h1841);
        {on, pgood} = 4'hF;
        rdc("byte on", 8'h78, 1'b0, 16'h0001);
    endtask

    initial begin
        {clk, vin_ov, vin_uv, vin_ok, iin_oc, ot_f, ot_w, ut_f} = 8'h00;
        {mem_f, proc_f, comm_o, logic_o, vend, oth} = 6'h00;
        {vov, vuv, vmax, ioc, iocuv, ishr} = 12'h000;
        {on, pgood} = 4'hF;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_fall();
        t_vout();
        t_iout();
        t_input();
        t_temp();
        t_cml();
        t_off();
        end_of_test();
    end
endmodule // pbs_status_bank_test
`default_nettype wire
